// File: design/asram_params.svh
// Timing and field constants for the host-side controller of an
// 8,192 x 9 asynchronous static memory; assumes a 40 MHz system clock.
// Overview of operation
// - Both selects on, strobe low: device takes data
// - Read cycle at least grade time; data follows
// - Write cycle and selection length per grade
// - Write strobe low at least grade pulse width
// - Write ends on strobe or either select edge
`ifndef ASRAM_PARAMS_SVH
`define ASRAM_PARAMS_SVH

`define ASRAM_WORDS 8192
`define ASRAM_ADDR_W 13
`define ASRAM_DATA_W 9
`define ASRAM_CLK_PERIOD_NS 25
`define ASRAM_SYNC_STAGES 2
`define ASRAM_GRADES 3

// Per-grade figures in ns: grade 0, 1, 2
`define ASRAM_T_RC(g) ((g) == 0 ? 35 : (g) == 1 ? 45 : 55)
`define ASRAM_T_ACC(g) ((g) == 0 ? 35 : (g) == 1 ? 45 : 55)
`define ASRAM_T_CO1(g) ((g) == 0 ? 35 : (g) == 1 ? 45 : 45)
`define ASRAM_T_CO2(g) ((g) == 0 ? 25 : (g) == 1 ? 25 : 30)
`define ASRAM_T_OE(g) ((g) == 0 ? 20 : (g) == 1 ? 20 : 25)
`define ASRAM_T_CHZ(g) 20
`define ASRAM_T_OHZ(g) ((g) == 0 ? 10 : (g) == 1 ? 10 : 15)
`define ASRAM_T_WC(g) ((g) == 0 ? 35 : (g) == 1 ? 45 : 55)
`define ASRAM_T_CW(g) ((g) == 0 ? 30 : (g) == 1 ? 40 : 50)
`define ASRAM_T_WP(g) ((g) == 0 ? 25 : (g) == 1 ? 35 : 45)
`define ASRAM_T_DS(g) ((g) == 0 ? 15 : (g) == 1 ? 20 : 20)

// Least time in ns to whole clock cycles, never below one
`define ASRAM_CYC_UP(t) (((t) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS < 1 ? 1 : \
    ((t) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)

`endif

// File: design/asram_pkg.sv
// Types shared by the static memory host controller.
// Assumes asram_params.svh is on the include path.
`include "asram_params.svh"

package asram_pkg;

    typedef logic [`ASRAM_ADDR_W-1:0] asram_addr_t;
    typedef logic [`ASRAM_DATA_W-1:0] asram_data_t;

    typedef struct packed {
        logic write;
        asram_addr_t addr;
        asram_data_t data;
    } asram_req_s;

    typedef struct packed {
        logic write;
        asram_data_t data;
    } asram_rsp_s;

    // Control pins of the memory; the _n fields are active low
    typedef struct packed {
        asram_addr_t word_address;
        logic select_low_active_n;
        logic select_high_active;
        logic write_strobe_n;
        logic output_drive_n;
    } asram_pins_s;

    typedef enum logic [2:0] {
        ASRAM_IDLE,
        ASRAM_W_SETUP,
        ASRAM_W_PULSE,
        ASRAM_W_END,
        ASRAM_R_ACCESS,
        ASRAM_R_SYNC,
        ASRAM_TURN
    } asram_state_e;

endpackage

// File: design/asram_timer.sv
// Down-counter that times the strobe, access, sync and turnaround phases of a memory access.
// Loaded with the phase length minus one; done while the count is zero.
module asram_timer #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    output logic done_out
);

    logic [WIDTH-1:0] count;

    assign done_out = (count == '0);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            count <= '0;
        end else if (load_in) begin
            count <= value_in;
        end else if (!done_out) begin
            count <= count - 1'b1;
        end
    end

    // Refuse a counter too narrow to hold any phase
    if (WIDTH < 1) begin : g_bad_width
        $error("asram_timer: WIDTH must be at least 1");
    end

endmodule // asram_timer

// File: design/asram_ctrl.sv
// Host controller that runs reads and strobe-ended writes on an
// 8,192 x 9 asynchronous static memory through its pins.
// Assumes a 40 MHz sys_clk_in; the data pins arrive from outside this domain.
`include "asram_params.svh"

module asram_ctrl
    import asram_pkg::*;
#(
    parameter int SPEED_GRADE = 2,
    parameter int TIMER_W = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // User request side
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire asram_req_s req_in,
    output logic rsp_valid_out,
    output asram_rsp_s rsp_out,
    // Memory pins
    output asram_pins_s pins_out,
    input wire logic [`ASRAM_DATA_W-1:0] data_lines_in,
    output logic [`ASRAM_DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_out
);

    // Phase lengths in cycles, each the worst of the figures it must cover
    localparam int T_RC_NS = `ASRAM_T_RC(SPEED_GRADE);
    localparam int T_ACC_NS = `ASRAM_T_ACC(SPEED_GRADE);
    localparam int T_CO1_NS = `ASRAM_T_CO1(SPEED_GRADE);
    localparam int T_CO2_NS = `ASRAM_T_CO2(SPEED_GRADE);
    localparam int T_OE_NS = `ASRAM_T_OE(SPEED_GRADE);
    localparam int T_CHZ_NS = `ASRAM_T_CHZ(SPEED_GRADE);
    localparam int T_OHZ_NS = `ASRAM_T_OHZ(SPEED_GRADE);
    localparam int T_WC_NS = `ASRAM_T_WC(SPEED_GRADE);
    localparam int T_CW_NS = `ASRAM_T_CW(SPEED_GRADE);
    localparam int T_WP_NS = `ASRAM_T_WP(SPEED_GRADE);
    localparam int T_DS_NS = `ASRAM_T_DS(SPEED_GRADE);

    localparam int RC_CYC = `ASRAM_CYC_UP(T_RC_NS);
    localparam int ACC_CYC = `ASRAM_CYC_UP(T_ACC_NS);
    localparam int CO1_CYC = `ASRAM_CYC_UP(T_CO1_NS);
    localparam int CO2_CYC = `ASRAM_CYC_UP(T_CO2_NS);
    localparam int OE_CYC = `ASRAM_CYC_UP(T_OE_NS);
    localparam int CHZ_CYC = `ASRAM_CYC_UP(T_CHZ_NS);
    localparam int OHZ_CYC = `ASRAM_CYC_UP(T_OHZ_NS);
    localparam int WC_CYC = `ASRAM_CYC_UP(T_WC_NS);
    localparam int CW_CYC = `ASRAM_CYC_UP(T_CW_NS);
    localparam int WP_CYC = `ASRAM_CYC_UP(T_WP_NS);
    localparam int DS_CYC = `ASRAM_CYC_UP(T_DS_NS);

    localparam int READ_A = (RC_CYC > ACC_CYC) ? RC_CYC : ACC_CYC;
    localparam int READ_B = (CO1_CYC > CO2_CYC) ? CO1_CYC : CO2_CYC;
    localparam int READ_C = (READ_A > READ_B) ? READ_A : READ_B;
    localparam int READ_CYC = (READ_C > OE_CYC) ? READ_C : OE_CYC;
    localparam int PULSE_A = (WP_CYC > DS_CYC) ? WP_CYC : DS_CYC;
    localparam int PULSE_B = (PULSE_A > CW_CYC - 1) ? PULSE_A : CW_CYC - 1;
    // Setup and end cycles frame the strobe; stretch the strobe if the cycle is short
    localparam int PULSE_CYC = (PULSE_B + 2 >= WC_CYC) ? PULSE_B : WC_CYC - 2;
    localparam int TURN_CYC = (CHZ_CYC > OHZ_CYC) ? CHZ_CYC : OHZ_CYC;

    localparam logic [TIMER_W-1:0] READ_LOAD = TIMER_W'(READ_CYC - 1);
    localparam logic [TIMER_W-1:0] SYNC_LOAD = TIMER_W'(`ASRAM_SYNC_STAGES - 1);
    localparam logic [TIMER_W-1:0] PULSE_LOAD = TIMER_W'(PULSE_CYC - 1);
    localparam logic [TIMER_W-1:0] TURN_LOAD = TIMER_W'(TURN_CYC - 1);
    localparam logic [TIMER_W-1:0] ONE_LOAD = '0;

    // Refuse grades and timer widths that the phase counts cannot serve
    if (SPEED_GRADE < 0 || SPEED_GRADE >= `ASRAM_GRADES) begin : g_bad_grade
        $error("asram_ctrl: SPEED_GRADE out of range");
    end
    if ((1 << TIMER_W) < READ_CYC || (1 << TIMER_W) < PULSE_CYC ||
        (1 << TIMER_W) < TURN_CYC) begin : g_bad_timer
        $error("asram_ctrl: TIMER_W too narrow for the phase lengths");
    end

    asram_state_e state;
    asram_state_e next_state;
    asram_req_s held;
    asram_pins_s next_pins;
    logic [`ASRAM_DATA_W-1:0] sync1;
    logic [`ASRAM_DATA_W-1:0] sync2;
    logic phase_done;
    logic timer_load;
    logic [TIMER_W-1:0] timer_value;
    logic next_oe;

    wire accept = req_valid_in && req_ready_out;
    wire capture = (state == ASRAM_R_SYNC) && phase_done;
    wire write_done = (state == ASRAM_W_END);

    assign req_ready_out = (state == ASRAM_IDLE);

    asram_timer #(
        .WIDTH(TIMER_W)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .load_in(timer_load),
        .value_in(timer_value),
        .done_out(phase_done)
    );

    // Sequencer; a read ends in a turnaround so the memory lets go of the lines
    always_comb begin
        next_state = state;
        timer_load = 1'b0;
        timer_value = ONE_LOAD;
        unique case (state)
            ASRAM_IDLE: begin
                if (accept) begin
                    timer_load = 1'b1;
                    if (req_in.write) begin
                        next_state = ASRAM_W_SETUP;
                    end else begin
                        next_state = ASRAM_R_ACCESS;
                        timer_value = READ_LOAD;
                    end
                end
            end
            ASRAM_W_SETUP: begin
                next_state = ASRAM_W_PULSE;
                timer_load = 1'b1;
                timer_value = PULSE_LOAD;
            end
            ASRAM_W_PULSE: begin
                if (phase_done) begin
                    next_state = ASRAM_W_END;
                end
            end
            ASRAM_W_END: begin
                next_state = ASRAM_IDLE;
            end
            ASRAM_R_ACCESS: begin
                if (phase_done) begin
                    next_state = ASRAM_R_SYNC;
                    timer_load = 1'b1;
                    timer_value = SYNC_LOAD;
                end
            end
            ASRAM_R_SYNC: begin
                if (phase_done) begin
                    next_state = ASRAM_TURN;
                    timer_load = 1'b1;
                    timer_value = TURN_LOAD;
                end
            end
            ASRAM_TURN: begin
                if (phase_done) begin
                    next_state = ASRAM_IDLE;
                end
            end
        endcase
    end

    // Pin levels for the coming state
    wire sel_next = (next_state != ASRAM_IDLE) && (next_state != ASRAM_TURN);
    wire read_next = (next_state == ASRAM_R_ACCESS) || (next_state == ASRAM_R_SYNC);
    wire write_next = (next_state == ASRAM_W_SETUP) || (next_state == ASRAM_W_PULSE) ||
        (next_state == ASRAM_W_END);
    wire [`ASRAM_ADDR_W-1:0] addr_next = accept ? req_in.addr : held.addr;
    wire [`ASRAM_DATA_W-1:0] data_next = accept ? req_in.data : held.data;

    always_comb begin
        next_pins.word_address = addr_next;
        // Deselected idle puts the memory into standby and floats it
        next_pins.select_low_active_n = !sel_next;
        next_pins.select_high_active = sel_next;
        // Selects and strobe overlap only in the pulse; the strobe ends the write
        next_pins.write_strobe_n = (next_state != ASRAM_W_PULSE);
        // Drive enable low only while reading, so writes never meet read data
        next_pins.output_drive_n = !read_next;
        // Host drives only in write states, where the memory output stays off
        next_oe = write_next;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ASRAM_IDLE;
            held <= '0;
        end else begin
            state <= next_state;
            if (accept) begin
                held <= req_in;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pins_out <= '{word_address: '0, select_low_active_n: 1'b1, select_high_active: 1'b0,
                write_strobe_n: 1'b1, output_drive_n: 1'b1};
            data_lines_out <= '0;
            data_lines_oe_out <= 1'b0;
        end else begin
            pins_out <= next_pins;
            data_lines_out <= data_next;
            data_lines_oe_out <= next_oe;
        end
    end

    // Data pins come from outside the clock domain
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= data_lines_in;
            sync2 <= sync1;
        end
    end

    // Read data is taken once it has settled through both stages
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rsp_valid_out <= 1'b0;
            rsp_out <= '0;
        end else begin
            rsp_valid_out <= capture || write_done;
            if (capture) begin
                rsp_out <= '{write: 1'b0, data: sync2};
            end else if (write_done) begin
                rsp_out <= '{write: 1'b1, data: held.data};
            end
        end
    end

endmodule // asram_ctrl

// File: test/asram_ctrl_properties.sv
// Port-level checks for the static memory host controller.
// Assumes the default speed grade and the single sys_clk_in domain.
`include "asram_params.svh"

module asram_ctrl_properties
    import asram_pkg::*;
#(
    parameter int SPEED_GRADE = 2,
    parameter int TIMER_W = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire asram_req_s req_in,
    input wire logic rsp_valid_out,
    input wire asram_rsp_s rsp_out,
    input wire asram_pins_s pins_out,
    input wire logic [`ASRAM_DATA_W-1:0] data_lines_in,
    input wire logic [`ASRAM_DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    logic sel;
    logic take;
    assign sel = !pins_out.select_low_active_n && pins_out.select_high_active;
    assign take = req_valid_in && req_ready_out;

    a_no_bus_fight: assert property (data_lines_oe_out |-> pins_out.output_drive_n)
        else $error("host drives data while memory output is on");
    a_write_setup: assert property (take && req_in.write |=> sel &&
        data_lines_oe_out && pins_out.word_address == $past(req_in.addr) &&
        data_lines_out == $past(req_in.data)) else $error("write setup pins wrong");
    a_strobe_width: assert property ($fell(pins_out.write_strobe_n) |->
        !pins_out.write_strobe_n [*2]) else $error("write strobe too short");
    a_strobe_in_sel: assert property (!pins_out.write_strobe_n |->
        sel && data_lines_oe_out && $stable(data_lines_out)) else $error("strobe outside select");
    a_write_end: assert property ($rose(pins_out.write_strobe_n) |->
        sel && data_lines_oe_out && $past(sel, 3)) else $error("write selection too short");
    a_read_drive: assert property (!pins_out.output_drive_n |->
        sel && pins_out.write_strobe_n && !data_lines_oe_out) else $error("bad read pins");
    a_read_access: assert property (take && !req_in.write |=>
        pins_out.word_address == $past(req_in.addr) ##1
        (sel && !pins_out.output_drive_n && $stable(pins_out.word_address)) [*4])
        else $error("read access window too short");
    a_read_answer: assert property (take && !req_in.write |->
        ##6 rsp_valid_out && !rsp_out.write) else $error("read answer late or missing");
    a_write_answer: assert property (take && req_in.write |-> ##5 rsp_valid_out &&
        rsp_out.write && rsp_out.data == $past(req_in.data, 5)) else $error("write answer wrong");
    a_idle_standby: assert property (req_ready_out |->
        pins_out.select_low_active_n && pins_out.write_strobe_n && !data_lines_oe_out)
        else $error("idle not in standby");
endmodule // asram_ctrl_properties

bind asram_ctrl asram_ctrl_properties #(.SPEED_GRADE(SPEED_GRADE), .TIMER_W(TIMER_W)) u_props (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .pins_out(pins_out), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out));

// File: test/asram_mem_model.sv
// Behavioural 8,192 x 9 asynchronous static memory at the controller pins.
// Assumes the bench resolves the shared data lines from both drivers.
`include "asram_params.svh"

module asram_mem_model
    import asram_pkg::*;
#(
    parameter int ACC_NS = 55,
    parameter int WP_NS = 45,
    parameter int CW_NS = 50,
    parameter int HOLD_NS = 5
) (
    input wire asram_pins_s pins_in,
    input wire logic [`ASRAM_DATA_W-1:0] data_in,
    output logic [`ASRAM_DATA_W-1:0] data_out,
    output logic drive_out,
    output int faults_out
);
    timeunit 1ns;
    timeprecision 1ps;
    asram_data_t mem [`ASRAM_WORDS];
    logic sel;
    logic wr_on;
    realtime t_chg = 0;
    realtime t_sel = 0;
    realtime t_wr = 0;
    assign sel = !pins_in.select_low_active_n &&
        pins_in.select_high_active;
    assign wr_on = sel && !pins_in.write_strobe_n;
    assign drive_out = sel && !pins_in.output_drive_n &&
        pins_in.write_strobe_n;
    initial begin
        data_out = '0;
        faults_out = 0;
    end
    always @(pins_in.word_address or drive_out) t_chg = $realtime;
    always @(posedge sel) t_sel = $realtime;
    always @(posedge wr_on) t_wr = $realtime;
    // Word is stored when the overlap of strobe and both selects ends
    always @(negedge wr_on) begin
        if ($realtime - t_wr < WP_NS || $realtime - t_sel < CW_NS) begin
            faults_out++;
        end
        mem[pins_in.word_address] = data_in;
    end
    // Lines not yet valid show a changing pattern once the old word's hold time has passed; released lines show it at once
    always begin
        #1;
        if (drive_out && $realtime - t_chg >= ACC_NS) begin
            data_out = mem[pins_in.word_address];
        end else if (!drive_out || $realtime - t_chg >= HOLD_NS) begin
            // Old word stays on the lines for the hold time after the address moves
            data_out = ~data_out;
        end
    end
endmodule // asram_mem_model

// File: test/async_sram_8k_by_9_bench.sv
// Self-checking bench for the static memory host controller.
// Assumes the default speed grade; the memory model stands at the pins.
`include "asram_params.svh"
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end

module async_sram_8k_by_9_bench
    import asram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, reset_in, req_valid_in, req_ready_out, rsp_valid_out, oe, drive;
    asram_req_s req_in;
    asram_rsp_s rsp_out;
    asram_pins_s pins;
    asram_data_t host_data, mem_data, bus;
    int errors = 0;
    int comparisons = 0;
    int faults;
    asram_rsp_s r;
    int lat;
    assign bus = oe ? host_data : mem_data;

    asram_ctrl u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
        .req_ready_out(req_ready_out), .req_in(req_in), .rsp_valid_out(rsp_valid_out),
        .rsp_out(rsp_out), .pins_out(pins), .data_lines_in(bus), .data_lines_out(host_data),
        .data_lines_oe_out(oe));
    asram_mem_model u_mem (.pins_in(pins), .data_in(bus), .data_out(mem_data),
        .drive_out(drive), .faults_out(faults));

    initial begin
        sys_clk_in = 0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Entered 1 ns after an edge; returns 1 ns after the answer's edge
    task automatic do_req(input logic wr, input asram_addr_t a, input asram_data_t d);
        int n = 0;
        req_in = '{write: wr, addr: a, data: d};
        req_valid_in = 1;
        while (req_ready_out !== 1'b1 && n < 20) begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        @(posedge sys_clk_in);
        #1 req_valid_in = 0;
        lat = 0;
        while (rsp_valid_out !== 1'b1 && lat < 20) begin
            @(posedge sys_clk_in);
            #1 lat++;
        end
        r = rsp_out;
    endtask

    task automatic t_reset_state;
        `CHECK(pins.select_low_active_n, 1'b1)
        `CHECK(pins.select_high_active, 1'b0)
        `CHECK(pins.write_strobe_n, 1'b1)
        `CHECK(pins.output_drive_n, 1'b1)
        `CHECK(oe, 1'b0)
        `CHECK(drive, 1'b0)
        `CHECK(rsp_valid_out, 1'b0)
        `CHECK(req_ready_out, 1'b1)
    endtask

    task automatic t_write_read;
        asram_addr_t a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        asram_data_t d [4] = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};
        foreach (a[i]) begin
            do_req(1'b1, a[i], d[i]);
            `CHECK(lat, 4)
            `CHECK(r, {1'b1, d[i]})
        end
        foreach (a[i]) begin
            do_req(1'b0, a[i], 9'h000);
            `CHECK(lat, 5)
            `CHECK(r, {1'b0, d[i]})
        end
    endtask

    task automatic t_overwrite;
        do_req(1'b1, 13'h0aaa, 9'h0f0);
        do_req(1'b0, 13'h0aaa, 9'h000);
        `CHECK(r.data, 9'h0f0)
        do_req(1'b0, 13'h1555, 9'h000);
        `CHECK(r.data, 9'h0aa)
    endtask

    task automatic t_mid_reset;
        // Let the read turnaround pass so the write is really taken
        @(posedge sys_clk_in);
        #1 req_in = '{write: 1'b1, addr: 13'h0000, data: 9'h07e};
        req_valid_in = 1;
        @(posedge sys_clk_in);
        #1 `CHECK(oe, 1'b1)
        reset_in = 1;
        req_valid_in = 0;
        #1 `CHECK({pins.select_low_active_n, pins.write_strobe_n, oe}, 3'h6)
        @(posedge sys_clk_in);
        #1 reset_in = 0;
        do_req(1'b0, 13'h0000, 9'h000);
        `CHECK(r.data, 9'h1ff)
    endtask

    initial begin
        reset_in = 1;
        req_valid_in = 0;
        req_in = '0;
        repeat (20) @(posedge sys_clk_in);
        #1 reset_in = 0;
        t_reset_state;
        t_write_read;
        t_overwrite;
        t_mid_reset;
        `CHECK(faults, 0)
        end_of_test;
    end

    initial begin
        repeat (2000) @(posedge sys_clk_in);
        errors++;
        end_of_test;
    end
endmodule // async_sram_8k_by_9_bench
